/* File: wdog_top.sv */
// windowed watchdog with clock monitor behind an apb slave
// assumes idle_tick is a one-cycle enable on ref_clk, mode inputs are
// synchronous, and the fault pin is open drain with an external pull-up
//
// Function
// - windows counted in idle timer ticks; lower limit fixed at 2048 ticks.
// - window select bits 7:6 pick upper limit 8k, 16k, 32k, 64k ticks.
// - bits 5:1 carry the fixed key; device checks it on every write.
// - bit 0 enables the clock monitor.
// - watchdog and fault pin exist only while option bit 2 is zero.
// - detectors idle in reset; leave reset with max window, monitor on.
// - only the first keyed write after reset sets window and monitor.
// - later writes compare every bit against the locked value.
// - matching write restarts window; any field mismatch is an error.
// - no valid service before upper limit gives an error.
// - service before the lower limit gives an error, except the first after reset.
// - boot rom entry services at once and suppresses the lower check.
// - error pulls pin low until seen low, then 16-32 cycles more.
// - window restarts when the fault pin returns high.
// - service writes while the pin is driven are ignored; here only in the watchdog fault sequence, not during monitor drive.
// - monitor holds pin low while clock slow, frees it after recovery.
// - never flag above 5 kHz, always flag below 10 Hz.
// - a clock that never starts is a continuous error from reset.
// - pin low at power-up: watchdog times out, then pin goes high.
// - watchdog frozen in halt and idle; clock monitor keeps running.
// - service register reads return zeros in the key field.
// - leaving idle mode performs a hardware service.
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
module wdog_top #(
    parameter int CM_TIMEOUT_CYCLES = wdog_pkg::CM_TIMEOUT_CYCLES
) (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // timing and power modes
    input  wire logic        idle_tick,
    input  wire logic        low_power_halt,
    input  wire logic        low_power_idle,
    input  wire logic        boot_rom_active,
    // monitored instruction clock
    input  wire logic        inst_clk_in,
    // open-drain fault pin, active low
    input  wire logic        fault_pin_in,
    output logic             fault_pin_out,
    output logic             fault_pin_oe
);
    wdt_link_if lnk (.ref_clk(ref_clk), .arst_n(arst_n));

    window_timer u_timer (.lnk(lnk));

    clock_monitor #(
        .TIMEOUT_CYCLES(CM_TIMEOUT_CYCLES)
    ) u_clkmon (
        .lnk        (lnk),
        .inst_clk_in(inst_clk_in)
    );

    wdog_pkg::fault_state_t state_ff;
    wdog_pkg::fault_state_t nxt_state;

    logic [7:0]  svc_ff;
    logic [7:0]  ctrl_ff;
    logic        locked_ff;
    logic        bypass_ff;
    logic [5:0]  hold_ff;
    logic        pin_s1_ff;
    logic        pin_s2_ff;
    logic        pin_s3_ff;
    logic        pin_lvl_ff;
    logic        idle_prev_ff;
    logic        halt_prev_ff;
    logic        boot_prev_ff;
    logic        oe_ff;
    logic [31:0] prdata_ff;

    logic        wd_enable;
    logic        acc;
    logic        mapped;
    logic        svc_wr;
    logic        key_ok;
    logic        fields_ok;
    logic        early_bad;
    logic        svc_ok;
    logic        svc_bad;
    logic        wd_err;
    logic        hw_service;
    logic [7:0]  wr_byte;

    assign wd_enable = !ctrl_ff[wdog_pkg::CTRL_OPT_BIT];

    // apb decode; always zero wait states
    assign acc     = psel && penable;
    assign mapped  = paddr == wdog_pkg::ADDR_SERVICE ||
                     paddr == wdog_pkg::ADDR_CTRL ||
                     paddr == wdog_pkg::ADDR_STATUS;
    assign pready  = 1'b1;
    assign pslverr = acc && !mapped;
    assign prdata  = prdata_ff;
    assign wr_byte = pwdata[7:0];
    assign svc_wr  = acc && pwrite && paddr == wdog_pkg::ADDR_SERVICE;

    // service evaluation
    assign key_ok    = wr_byte[wdog_pkg::SVC_KEY_MSB:wdog_pkg::SVC_KEY_LSB]
                       == wdog_pkg::KEY_VALUE;
    assign fields_ok = wr_byte == svc_ff;
    // the very first service may land inside the lower window
    assign early_bad = locked_ff && lnk.early && !bypass_ff;
    assign svc_ok    = svc_wr && state_ff == wdog_pkg::F_IDLE && wd_enable &&
                       (locked_ff ? fields_ok : key_ok) && !early_bad;
    assign svc_bad   = svc_wr && state_ff == wdog_pkg::F_IDLE && wd_enable &&
                       !((locked_ff ? fields_ok : key_ok) && !early_bad);
    assign wd_err    = svc_bad || (state_ff == wdog_pkg::F_IDLE &&
                       wd_enable && lnk.expired);

    // hardware services on idle/halt exit and boot rom entry
    assign hw_service = (idle_prev_ff && !low_power_idle) ||
                        (halt_prev_ff && !low_power_halt) ||
                        (boot_rom_active && !boot_prev_ff);

    assign lnk.tick      = idle_tick;
    assign lnk.win_sel   = svc_ff[wdog_pkg::SVC_WIN_MSB:wdog_pkg::SVC_WIN_LSB];
    assign lnk.cm_enable = wd_enable && svc_ff[wdog_pkg::SVC_CM_BIT];
    assign lnk.inhibit   = low_power_halt || low_power_idle || !wd_enable ||
                           state_ff != wdog_pkg::F_IDLE;
    assign lnk.restart   = svc_ok || hw_service ||
                           (state_ff == wdog_pkg::F_REL && pin_lvl_ff);

    // fault pin input: three stages, level taken when last two agree
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pin_s1_ff  <= 1'b1;
            pin_s2_ff  <= 1'b1;
            pin_s3_ff  <= 1'b1;
            pin_lvl_ff <= 1'b1;
        end
        else
        begin
            pin_s1_ff <= fault_pin_in;
            pin_s2_ff <= pin_s1_ff;
            pin_s3_ff <= pin_s2_ff;
            if (pin_s2_ff == pin_s3_ff)
                pin_lvl_ff <= pin_s3_ff;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            idle_prev_ff <= 1'b0;
            halt_prev_ff <= 1'b0;
            boot_prev_ff <= 1'b0;
        end
        else
        begin
            idle_prev_ff <= low_power_idle;
            halt_prev_ff <= low_power_halt;
            boot_prev_ff <= boot_rom_active;
        end
    end

    // service register: reset to max window, monitor on, then lock once
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            svc_ff    <= wdog_pkg::SVC_RESET;
            locked_ff <= 1'b0;
        end
        else if (svc_ok && !locked_ff)
        begin
            svc_ff    <= {wr_byte[wdog_pkg::SVC_WIN_MSB:wdog_pkg::SVC_WIN_LSB],
                          wdog_pkg::KEY_VALUE,
                          wr_byte[wdog_pkg::SVC_CM_BIT]};
            locked_ff <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            ctrl_ff <= wdog_pkg::CTRL_RESET;
        else if (acc && pwrite && paddr == wdog_pkg::ADDR_CTRL)
            ctrl_ff <= wr_byte;
    end

    // lower check stays off from boot entry until a user service after exit
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            bypass_ff <= 1'b0;
        else if (boot_rom_active && !boot_prev_ff)
            bypass_ff <= 1'b1;
        else if (svc_ok && !boot_rom_active)
            bypass_ff <= 1'b0;
    end

    // fault sequence
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            wdog_pkg::F_IDLE:
                if (wd_err)
                    nxt_state = wdog_pkg::F_PULL;
            wdog_pkg::F_PULL:
                if (!pin_lvl_ff)
                    nxt_state = wdog_pkg::F_HOLD;
            wdog_pkg::F_HOLD:
                if (hold_ff == wdog_pkg::HOLD_CYCLES - 6'h01)
                    nxt_state = wdog_pkg::F_REL;
            wdog_pkg::F_REL:
                if (pin_lvl_ff)
                    nxt_state = wdog_pkg::F_IDLE;
            default:
                nxt_state = wdog_pkg::F_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            state_ff <= wdog_pkg::F_IDLE;
        else
            state_ff <= nxt_state;
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            hold_ff <= 6'h00;
        else if (state_ff == wdog_pkg::F_HOLD)
            hold_ff <= hold_ff + 6'h01;
        else
            hold_ff <= 6'h00;
    end

    // either detector pulls the shared pin; released in reset
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            oe_ff <= 1'b0;
        else
            oe_ff <= wd_enable && (nxt_state == wdog_pkg::F_PULL ||
                     nxt_state == wdog_pkg::F_HOLD || lnk.cm_fault);
    end

    assign fault_pin_out = 1'b0;
    assign fault_pin_oe  = oe_ff;

    // read data captured in the setup phase
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            prdata_ff <= 32'h00000000;
        else if (psel && !penable)
        begin
            prdata_ff <= 32'h00000000;
            case (paddr)
                wdog_pkg::ADDR_SERVICE:
                    prdata_ff[7:0] <= svc_ff & wdog_pkg::SVC_RD_MASK;
                wdog_pkg::ADDR_CTRL:
                    prdata_ff[7:0] <= ctrl_ff;
                wdog_pkg::ADDR_STATUS:
                begin
                    prdata_ff[wdog_pkg::ST_FAULT_BIT]  <=
                        state_ff != wdog_pkg::F_IDLE;
                    prdata_ff[wdog_pkg::ST_CLKERR_BIT] <= lnk.cm_fault;
                    prdata_ff[wdog_pkg::ST_LOCK_BIT]   <= locked_ff;
                    prdata_ff[wdog_pkg::ST_PIN_BIT]    <= pin_lvl_ff;
                    prdata_ff[wdog_pkg::ST_BYPASS_BIT] <= bypass_ff;
                    prdata_ff[wdog_pkg::ST_EARLY_BIT]  <= lnk.early;
                end
                default:
                    prdata_ff <= 32'h00000000;
            endcase
        end
    end

    a_key_hidden: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        acc && !pwrite && paddr == wdog_pkg::ADDR_SERVICE
        |-> prdata[5:1] == 5'h00)
        else $error("key visible on read");

    a_bad_key_err: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        svc_wr && state_ff == wdog_pkg::F_IDLE && wd_enable && !key_ok
        |=> state_ff == wdog_pkg::F_PULL ##1 fault_pin_oe)
        else $error("bad key not flagged");

    a_early_err: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        svc_wr && state_ff == wdog_pkg::F_IDLE && wd_enable && locked_ff &&
        lnk.early && !bypass_ff |=> state_ff == wdog_pkg::F_PULL)
        else $error("early service not flagged");

    a_ignore_fault: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        svc_wr && state_ff != wdog_pkg::F_IDLE
        |=> $stable(svc_ff) && $stable(locked_ff))
        else $error("service taken during fault");

    a_lock_hold: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        locked_ff |=> locked_ff && $stable(svc_ff))
        else $error("locked choices changed");

    a_hold_span: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        state_ff == wdog_pkg::F_PULL && !pin_lvl_ff
        |=> (fault_pin_oe && state_ff == wdog_pkg::F_HOLD) [*8]
        ##17 state_ff == wdog_pkg::F_REL)
        else $error("hold time wrong");

    a_cm_drives: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        lnk.cm_fault |=> fault_pin_oe)
        else $error("clock fault not on pin");

    a_expire_err: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        state_ff == wdog_pkg::F_IDLE && wd_enable && lnk.expired
        |=> state_ff == wdog_pkg::F_PULL)
        else $error("expiry not flagged");

endmodule : wdog_top

/* File: wdog_pkg.sv */
// constants and types shared by the watchdog and clock monitor
// assumes 32-bit apb data and one aligned word per register
package wdog_pkg;

    // register byte addresses
    localparam logic [11:0] ADDR_SERVICE = 12'h000;
    localparam logic [11:0] ADDR_CTRL    = 12'h004;
    localparam logic [11:0] ADDR_STATUS  = 12'h008;

    // service register layout
    localparam int          SVC_WIN_MSB = 7;
    localparam int          SVC_WIN_LSB = 6;
    localparam int          SVC_KEY_MSB = 5;
    localparam int          SVC_KEY_LSB = 1;
    localparam int          SVC_CM_BIT  = 0;
    localparam logic [4:0]  KEY_VALUE   = 5'h0c;
    localparam logic [7:0]  SVC_RESET   = 8'hd9;
    localparam logic [7:0]  SVC_RD_MASK = 8'hc1;

    // control register: option bit, 1 removes the watchdog
    localparam int          CTRL_OPT_BIT = 2;
    localparam logic [7:0]  CTRL_RESET   = 8'h00;

    // status register fields
    localparam int          ST_FAULT_BIT  = 0;
    localparam int          ST_CLKERR_BIT = 1;
    localparam int          ST_LOCK_BIT   = 2;
    localparam int          ST_PIN_BIT    = 3;
    localparam int          ST_BYPASS_BIT = 4;
    localparam int          ST_EARLY_BIT  = 5;

    // window limits in idle timer ticks
    localparam logic [16:0] LOWER_TICKS      = 17'h00800;
    localparam logic [16:0] UPPER_BASE_TICKS = 17'h02000;

    // fault pin hold after the pin is seen low, ref_clk cycles (16..32)
    localparam logic [5:0]  HOLD_CYCLES      = 6'h18;
    // instruction clock edges needed before the monitor lets go
    localparam logic [5:0]  CM_RECOVER_EDGES = 6'h18;

    // clock monitor reject time, between 200 us (5 kHz) and 100 ms
    localparam int          CLK_PERIOD_NS     = 10;
    localparam int          CM_TIMEOUT_NS     = 1000000;
    localparam int          CM_TIMEOUT_CYCLES = CM_TIMEOUT_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {F_IDLE, F_PULL, F_HOLD, F_REL} fault_state_t;

    function automatic logic [16:0] upper_limit(input logic [1:0] sel);
        upper_limit = UPPER_BASE_TICKS << sel;
    endfunction : upper_limit

endpackage : wdog_pkg

/* File: wdt_link_if.sv */
// signals between the watchdog core, its window timer and clock monitor
// assumes a single ref_clk domain with asynchronous active-low reset
`timescale 1ns/10ps
interface wdt_link_if (
    input wire logic ref_clk,
    input wire logic arst_n
);
    logic       restart;
    logic       tick;
    logic       inhibit;
    logic [1:0] win_sel;
    logic       early;
    logic       expired;
    logic       cm_enable;
    logic       cm_fault;

    modport core   (input ref_clk, arst_n, early, expired, cm_fault,
                    output restart, tick, inhibit, win_sel, cm_enable);
    modport timer  (input ref_clk, arst_n, restart, tick, inhibit, win_sel,
                    output early, expired);
    modport clkmon (input ref_clk, arst_n, cm_enable, output cm_fault);
endinterface : wdt_link_if

/* File: window_timer.sv */
// service window counter clocked by idle timer ticks
// assumes tick is a one-cycle enable in the ref_clk domain
`timescale 1ns/10ps
module window_timer (
    wdt_link_if.timer lnk
);
    logic [16:0] cnt_ff;
    logic        at_top;

    // saturates so a later, smaller window still reads as expired
    assign at_top      = cnt_ff >= wdog_pkg::upper_limit(lnk.win_sel);
    assign lnk.expired = at_top;
    assign lnk.early   = cnt_ff < wdog_pkg::LOWER_TICKS;

    always_ff @(posedge lnk.ref_clk or negedge lnk.arst_n)
    begin
        if (!lnk.arst_n)
            cnt_ff <= 17'h00000;
        else if (lnk.restart)
            cnt_ff <= 17'h00000;
        else if (lnk.tick && !lnk.inhibit && !at_top)
            cnt_ff <= cnt_ff + 17'h00001;
    end

    a_restart_clears: assert property (
        @(posedge lnk.ref_clk) disable iff (!lnk.arst_n)
        lnk.restart |=> lnk.early && !lnk.expired)
        else $error("window not restarted");

    a_frozen_inhibit: assert property (
        @(posedge lnk.ref_clk) disable iff (!lnk.arst_n)
        lnk.inhibit && !lnk.restart |=> $stable(cnt_ff))
        else $error("window counted while inhibited");

endmodule : window_timer

/* File: clock_monitor.sv */
// slow or missing instruction clock detector
// assumes inst_clk_in is asynchronous to ref_clk
`timescale 1ns/10ps
module clock_monitor #(
    parameter int TIMEOUT_CYCLES = wdog_pkg::CM_TIMEOUT_CYCLES
) (
    // link to core
    wdt_link_if.clkmon lnk,
    // monitored clock
    input wire logic   inst_clk_in
);
    localparam int GW = $clog2(TIMEOUT_CYCLES + 1);
    localparam logic [GW-1:0] GAP_LAST = GW'(TIMEOUT_CYCLES - 1);

    logic          s1_ff;
    logic          s2_ff;
    logic          s3_ff;
    logic          rise;
    logic [GW-1:0] gap_ff;
    logic          slow_ff;
    logic [5:0]    good_ff;

    always_ff @(posedge lnk.ref_clk or negedge lnk.arst_n)
    begin
        if (!lnk.arst_n)
        begin
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
            s3_ff <= 1'b0;
        end
        else
        begin
            s1_ff <= inst_clk_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    assign rise = s2_ff && !s3_ff;

    always_ff @(posedge lnk.ref_clk or negedge lnk.arst_n)
    begin
        if (!lnk.arst_n)
            gap_ff <= '0;
        else if (rise)
            gap_ff <= '0;
        else if (gap_ff != GAP_LAST)
            gap_ff <= gap_ff + GW'(1);
    end

    // starts out slow: a dead oscillator is an error from reset on
    always_ff @(posedge lnk.ref_clk or negedge lnk.arst_n)
    begin
        if (!lnk.arst_n)
        begin
            slow_ff <= 1'b1;
            good_ff <= 6'h00;
        end
        else if (gap_ff == GAP_LAST && !rise)
        begin
            slow_ff <= 1'b1;
            good_ff <= 6'h00;
        end
        else if (slow_ff && rise)
        begin
            if (good_ff == wdog_pkg::CM_RECOVER_EDGES - 6'h01)
                slow_ff <= 1'b0;
            good_ff <= good_ff + 6'h01;
        end
    end

    assign lnk.cm_fault = lnk.cm_enable && slow_ff;

    a_slow_timeout: assert property (
        @(posedge lnk.ref_clk) disable iff (!lnk.arst_n)
        gap_ff == GAP_LAST && !rise |=> slow_ff)
        else $error("slow clock not flagged");

endmodule : clock_monitor

/* File: reset_circuit_model.sv */
// external reset circuitry on the open-drain fault pin
// assumes the pin has a pull-up and only the block, watchdog or clock monitor, pulls it low
`timescale 1ns/10ps
module reset_circuit_model (
    // pin drive from the block
    input  wire logic drv_oe,
    input  wire logic drv_val,
    // resolved pin level
    output logic      pin_level
);
    // released pin returns to the pull-up, it never keeps the last value
    assign pin_level = drv_oe ? drv_val : 1'b1;
endmodule : reset_circuit_model

/* File: tb_windowed_watchdog_clock_monitor.sv */
// self-checking bench for the windowed watchdog and clock monitor
// assumes wdog_pkg, the link interface and all design modules compiled
`timescale 1ns/10ps
module tb_windowed_watchdog_clock_monitor;
    logic        ref_clk, arst_n, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic        err, idle_tick, halt, idle, boot, inst_clk, inst_run;
    logic        pin, pout, poe;
    logic [7:0]  bad [3] = '{8'h58, 8'h1a, 8'h19};
    int          n_errors = 0;
    int          compares = 0;
    int          n;

`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; \
    $display("ERROR %0t got %h exp %h", $time, (a), (b)); end end

    wdog_top #(.CM_TIMEOUT_CYCLES(200)) u_wdog_top (
        .ref_clk(ref_clk), .arst_n(arst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .idle_tick(idle_tick),
        .low_power_halt(halt), .low_power_idle(idle),
        .boot_rom_active(boot), .inst_clk_in(inst_clk),
        .fault_pin_in(pin), .fault_pin_out(pout), .fault_pin_oe(poe)
    );

    reset_circuit_model u_reset_circuit_model (
        .drv_oe(poe), .drv_val(pout), .pin_level(pin)
    );

    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // monitored clock stands still while stopped
    initial
    begin
        inst_clk = 1'b0;
        forever #20 if (inst_run) inst_clk = ~inst_clk;
    end

    task close_out;
        begin
            $display("errors %0d compares %0d", n_errors, compares);
            if (n_errors == 0 && compares > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask : close_out

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        begin
            @(posedge ref_clk);
            psel <= 1'b1;
            pwrite <= wr;
            paddr <= a;
            pwdata <= d;
            @(posedge ref_clk);
            penable <= 1'b1;
            i = 0;
            do
            begin
                @(posedge ref_clk);
                i++;
            end
            while (pready !== 1'b1 && i < 50);
            q = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            if (i >= 50)
            begin
                n_errors++;
                close_out();
            end
        end
    endtask : apb

    task svc(input logic [7:0] d);
        begin
            apb(1'b1, wdog_pkg::ADDR_SERVICE, {24'h0, d});
        end
    endtask : svc

    // bounded wait for the pin drive to reach a level, sampled mid-cycle
    task wait_oe(input logic lvl, input int lim);
        begin
            n = 0;
            while (poe !== lvl && n < lim)
            begin
                @(negedge ref_clk);
                n++;
            end
            `CHK(poe, lvl)
            if (poe !== lvl)
                close_out();
        end
    endtask : wait_oe

    // counts cycles in which the pin is driven
    task quiet(input int cyc);
        begin
            n = 0;
            repeat (cyc)
            begin
                @(negedge ref_clk);
                if (poe !== 1'b0)
                    n++;
            end
        end
    endtask : quiet

    task do_reset;
        begin
            arst_n <= 1'b0;
            repeat (6) @(posedge ref_clk);
            arst_n <= 1'b1;
            inst_run = 1'b1;
        end
    endtask : do_reset

    initial
    begin
        {psel, penable, pwrite, halt, idle, boot, arst_n} = '0;
        {paddr, pwdata} = '0;
        idle_tick = 1'b1;
        inst_run = 1'b1;
        do_reset();
        wait_oe(1'b1, 4);
        wait_oe(1'b0, 3000);
        apb(1'b0, wdog_pkg::ADDR_SERVICE, 32'h0);
        `CHK(q[7:0], 8'hc1)
        svc(8'h18);
        quiet(200);
        `CHK(n, 0)
        apb(1'b0, wdog_pkg::ADDR_SERVICE, 32'h0);
        `CHK(q[7:0], 8'h00)
        inst_run = 1'b0;
        quiet(400);
        `CHK(n, 0)
        inst_run = 1'b1;
        svc(8'h18);
        wait_oe(1'b1, 4);
        `CHK({pready, pout}, 2'b10)
        wait_oe(1'b0, 100);
        `CHK(n >= 16 && n <= 32, 1'b1)
        quiet(2100);
        `CHK(n, 0)
        svc(8'h18);
        quiet(100);
        `CHK(n, 0)
        foreach (bad[i])
        begin
            quiet(2100);
            svc(bad[i]);
            wait_oe(1'b1, 4);
            svc(8'h5a); // ignored while driven
            wait_oe(1'b0, 100);
            `CHK(n > 8, 1'b1)
        end
        wait_oe(1'b1, 8300);
        `CHK(n >= 8192 && n <= 8210, 1'b1)
        wait_oe(1'b0, 100);
        @(posedge ref_clk);
        halt <= 1'b1;
        quiet(9000);
        `CHK(n, 0)
        @(posedge ref_clk);
        halt <= 1'b0;
        quiet(2100);
        svc(8'h18);
        quiet(2100);
        `CHK(n, 0)
        @(posedge ref_clk);
        idle <= 1'b1;
        quiet(100);
        @(posedge ref_clk);
        idle <= 1'b0;
        svc(8'h18);
        wait_oe(1'b1, 4);
        wait_oe(1'b0, 100);
        // let the window restart first, or the service is ignored
        quiet(8);
        @(posedge ref_clk);
        boot <= 1'b1;
        svc(8'h18);
        quiet(100);
        `CHK(n, 0)
        @(posedge ref_clk);
        boot <= 1'b0;
        apb(1'b0, 12'h00c, 32'h0);
        `CHK({err, q}, {1'b1, 32'h0})
        apb(1'b1, wdog_pkg::ADDR_CTRL, 32'h4);
        svc(8'h19);
        quiet(200);
        `CHK(n, 0)
        @(posedge ref_clk);
        do_reset();
        wait_oe(1'b1, 4);
        wait_oe(1'b0, 3000);
        inst_run = 1'b0;
        wait_oe(1'b1, 300);
        `CHK(n >= 190 && n <= 215, 1'b1)
        inst_run = 1'b1;
        wait_oe(1'b0, 300);
        `CHK(n >= 60 && n <= 140, 1'b1)
        svc(8'h59);
        wait_oe(1'b1, 16500);
        `CHK(n >= 16380 && n <= 16400, 1'b1)
        close_out();
    end
endmodule : tb_windowed_watchdog_clock_monitor
